// *** design/tsc_clk_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_clk_mux (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [4:0] src_lvl,
  input wire tsc_pkg::tsc_src_t req_src,
  input wire logic run,
  output logic sysclk,
  output tsc_pkg::tsc_src_t cur_src,
  output logic busy
);
  tsc_pkg::tsc_mux_state_t s_q;
  tsc_pkg::tsc_mux_state_t s_d;

  always_comb begin
    s_d = s_q;
    // Output frozen low once the old source is low, so no pulse is cut short
    s_d.clk = run && (s_q.ph inside {tsc_pkg::TSC_PH_IDLE, tsc_pkg::TSC_PH_OLD_LOW}) && src_lvl[s_q.cur];
    case (s_q.ph)
      tsc_pkg::TSC_PH_IDLE: begin
        if (req_src != s_q.cur) begin
          s_d.ph = tsc_pkg::TSC_PH_OLD_LOW;
        end
      end
      tsc_pkg::TSC_PH_OLD_LOW: begin
        if (!src_lvl[s_q.cur]) begin
          s_d.ph = tsc_pkg::TSC_PH_NEW_HIGH;
        end
      end
      tsc_pkg::TSC_PH_NEW_HIGH: begin
        if (src_lvl[req_src]) begin
          s_d.ph = tsc_pkg::TSC_PH_NEW_LOW;
        end
      end
      tsc_pkg::TSC_PH_NEW_LOW: begin
        if (!src_lvl[req_src]) begin
          s_d.cur = req_src;
          s_d.ph = tsc_pkg::TSC_PH_IDLE;
        end
      end
      default: s_d.ph = tsc_pkg::TSC_PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sysclk = s_q.clk;
  assign cur_src = s_q.cur;
  assign busy = (s_q.ph != tsc_pkg::TSC_PH_IDLE);

  mux_glitch_free_a: assert property (@(posedge ref_clk) disable iff (reset) $changed(s_q.cur) |-> !s_q.clk)
    else $error("system clock high at source change");
endmodule
`default_nettype wire

// *** design/tsc_clock_startup.sv ***
// Our own choices: the address map and the AXI4-Lite slave port.
`include "tsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tsc_clock_startup #(
  parameter int unsigned PLL_LOCK_CYC = `TSC_CYC(`TSC_PLL_LOCK_NS),
  parameter int unsigned POWERUP_CYC = `TSC_CYC(`TSC_POWERUP_NS),
  parameter int unsigned WARMUP_CYC = `TSC_CYC(`TSC_WARMUP_NS)
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [2:0] osc_mode_select,
  input wire logic int_ext_switchover_en,
  input wire logic pll_config_enable,
  input wire logic powerup_timer_en,
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  input wire logic lf_osc_lvl,
  input wire logic mf_osc_lvl,
  input wire logic hf_osc_lvl,
  input wire logic ext_osc_lvl,
  input wire logic sec_osc_lvl,
  input wire logic [`TSC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TSC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sysclk_o,
  output logic [2:0] sysclk_src_o,
  output logic pll_active_o,
  output logic pll_locked_o,
  output logic ext_osc_ready_flag,
  output logic irq_o
);
  localparam int unsigned INT_SWITCH_CYC = `TSC_CYC(`TSC_INT_SWITCH_NS);

  tsc_pkg::tsc_top_state_t s_q;
  tsc_pkg::tsc_top_state_t s_d;
  tsc_pkg::tsc_src_t tgt_now;
  tsc_pkg::tsc_src_t mux_src;
  logic ost_clr;
  logic sec_clr;
  logic ost_done;
  logic sec_done;
  logic [10:0] ost_tgt;
  logic mux_run;
  logic mux_busy;
  logic mux_clk;
  logic fin;
  logic [2:0] int_set;
  logic [2:0] int_clr;

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == `TSC_MODE_LOW_POWER_XTAL) || (mode == `TSC_MODE_XTAL) ||
                 (mode == `TSC_MODE_HIGH_SPEED_XTAL);
  endfunction

  function automatic tsc_pkg::tsc_src_t int_src(input logic [1:0] freq);
    if (freq == `TSC_FREQ_LOW) begin
      int_src = tsc_pkg::TSC_SRC_LF;
    end else if (freq == `TSC_FREQ_MID) begin
      int_src = tsc_pkg::TSC_SRC_MF;
    end else begin
      int_src = tsc_pkg::TSC_SRC_HF;
    end
  endfunction

  function automatic tsc_pkg::tsc_src_t tgt_src(input logic [1:0] sel, input logic [1:0] freq,
                                                 input logic [2:0] mode);
    if (sel[`TSC_SYSCLK_INTERNAL_BIT]) begin
      tgt_src = int_src(freq);
    end else if (sel == `TSC_SYSCLK_SECONDARY) begin
      tgt_src = tsc_pkg::TSC_SRC_SEC;
    end else if (mode == `TSC_MODE_INTERNAL) begin
      tgt_src = int_src(freq);
    end else begin
      tgt_src = tsc_pkg::TSC_SRC_PRI;
    end
  endfunction

  assign ost_tgt = is_crystal(s_q.osc_mode_select) ? `TSC_OSC_STARTUP_COUNT : `TSC_EXT_DIRECT_COUNT;

  tsc_edge_cnt u_ost (
    .ref_clk(ref_clk),
    .reset(reset),
    .osc_lvl(ext_osc_lvl),
    .clear(ost_clr),
    .target(ost_tgt),
    .done(ost_done)
  );

  tsc_edge_cnt u_sec (
    .ref_clk(ref_clk),
    .reset(reset),
    .osc_lvl(sec_osc_lvl),
    .clear(sec_clr),
    .target(`TSC_OSC_STARTUP_COUNT),
    .done(sec_done)
  );

  assign mux_run = (s_q.st == tsc_pkg::TSC_ST_RUN) || s_q.two_speed ||
                   (!s_q.boot && (s_q.st inside {tsc_pkg::TSC_ST_START, tsc_pkg::TSC_ST_TIMED,
                                                 tsc_pkg::TSC_ST_EDGES}));

  tsc_clk_mux u_mux (
    .ref_clk(ref_clk),
    .reset(reset),
    .src_lvl({sec_osc_lvl, ext_osc_lvl, hf_osc_lvl, mf_osc_lvl, lf_osc_lvl}),
    .req_src(s_q.want),
    .run(mux_run),
    .sysclk(mux_clk),
    .cur_src(mux_src),
    .busy(mux_busy)
  );

  always_comb begin
    s_d = s_q;
    ost_clr = 1'b0;
    sec_clr = 1'b0;
    fin = 1'b0;
    int_set = '0;
    int_clr = '0;
    tgt_now = tgt_src(s_q.sysclk_select, s_q.int_freq_sel, s_q.osc_mode_select);
    case (s_q.st)
      // Straps caught on the first edge after reset release
      tsc_pkg::TSC_ST_CAPTURE: begin
        s_d.osc_mode_select = osc_mode_select;
        s_d.int_ext_switchover_en = int_ext_switchover_en;
        s_d.pll_config_enable = pll_config_enable;
        s_d.powerup_timer_en = powerup_timer_en;
        s_d.cnt = 32'(POWERUP_CYC);
        s_d.st = tsc_pkg::TSC_ST_POWERUP;
      end
      tsc_pkg::TSC_ST_POWERUP: begin
        if (!s_q.powerup_timer_en || s_q.cnt == '0) begin
          s_d.st = tsc_pkg::TSC_ST_START;
          s_d.boot = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 32'd1;
        end
      end
      tsc_pkg::TSC_ST_START: begin
        s_d.tgt = tgt_now;
        s_d.wait_sec = 1'b0;
        if (tgt_now == tsc_pkg::TSC_SRC_SEC) begin
          sec_clr = 1'b1;
          s_d.wait_sec = 1'b1;
          s_d.st = tsc_pkg::TSC_ST_EDGES;
        end else if (tgt_now == tsc_pkg::TSC_SRC_PRI && is_crystal(s_q.osc_mode_select) &&
                     (s_q.boot || !s_q.ext_osc_ready_flag)) begin
          ost_clr = 1'b1;
          s_d.ext_osc_ready_flag = 1'b0;
          s_d.st = tsc_pkg::TSC_ST_EDGES;
          if (s_q.boot && s_q.int_ext_switchover_en && s_q.sysclk_select == `TSC_SYSCLK_PRIMARY) begin
            s_d.two_speed = 1'b1;
            s_d.want = int_src(s_q.int_freq_sel);
          end
        end else if (tgt_now == tsc_pkg::TSC_SRC_PRI && s_q.boot) begin
          ost_clr = 1'b1;
          s_d.st = tsc_pkg::TSC_ST_EDGES;
        end else if (s_q.boot) begin
          s_d.cnt = 32'(WARMUP_CYC);
          s_d.st = tsc_pkg::TSC_ST_TIMED;
        end else if (tgt_now == tsc_pkg::TSC_SRC_MF || tgt_now == tsc_pkg::TSC_SRC_HF) begin
          s_d.cnt = 32'(INT_SWITCH_CYC);
          s_d.st = tsc_pkg::TSC_ST_TIMED;
        end else begin
          s_d.want = tgt_now;
          s_d.st = tsc_pkg::TSC_ST_RUN;
        end
      end
      tsc_pkg::TSC_ST_TIMED: begin
        if (s_q.cnt == '0) begin
          fin = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 32'd1;
        end
      end
      tsc_pkg::TSC_ST_EDGES: begin
        fin = s_q.wait_sec ? sec_done : ost_done;
      end
      tsc_pkg::TSC_ST_RUN: begin
        if (tgt_now != s_q.tgt) begin
          s_d.st = tsc_pkg::TSC_ST_START;
          s_d.boot = 1'b0;
        end
      end
      tsc_pkg::TSC_ST_SLEEP: begin
        if (wake_cmd) begin
          s_d.st = tsc_pkg::TSC_ST_START;
          s_d.boot = 1'b1;
        end
      end
      default: s_d.st = tsc_pkg::TSC_ST_CAPTURE;
    endcase

    if (fin) begin
      s_d.want = s_q.tgt;
      s_d.st = tsc_pkg::TSC_ST_RUN;
      s_d.boot = 1'b0;
      s_d.two_speed = 1'b0;
      if (s_q.tgt == tsc_pkg::TSC_SRC_PRI && is_crystal(s_q.osc_mode_select)) begin
        s_d.ext_osc_ready_flag = 1'b1;
        int_set[`TSC_INT_READY] = 1'b1;
      end
    end

    if (sleep_cmd && (s_q.st inside {tsc_pkg::TSC_ST_START, tsc_pkg::TSC_ST_TIMED,
                                     tsc_pkg::TSC_ST_EDGES, tsc_pkg::TSC_ST_RUN})) begin
      s_d.st = tsc_pkg::TSC_ST_SLEEP;
      s_d.ext_osc_ready_flag = 1'b0;
      s_d.two_speed = 1'b0;
      ost_clr = 1'b1;
      if (s_q.st == tsc_pkg::TSC_ST_EDGES && !s_q.wait_sec) begin
        int_set[`TSC_INT_ABORT] = 1'b1;
      end
    end

    s_d.pll_on = s_q.pll_config_enable ? 1'b1 : s_q.pll_soft_enable;
    if (!s_q.pll_on) begin
      s_d.pll_locked = 1'b0;
      s_d.pll_cnt = 32'(PLL_LOCK_CYC);
    end else if (!s_q.pll_locked) begin
      if (s_q.pll_cnt == '0) begin
        s_d.pll_locked = 1'b1;
        int_set[`TSC_INT_PLL_LOCK] = 1'b1;
      end else begin
        s_d.pll_cnt = s_q.pll_cnt - 32'd1;
      end
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `TSC_RESP_OKAY;
      case (s_q.awaddr)
        `TSC_ADDR_OSC_CONTROL: begin
          if (s_q.wstrb[0]) begin
            s_d.sysclk_select = s_q.wdata[`TSC_CTRL_SYSCLK_SELECT];
            s_d.int_freq_sel = s_q.wdata[`TSC_CTRL_INT_FREQ_SEL];
            s_d.pll_soft_enable = s_q.wdata[`TSC_CTRL_PLL_SOFT];
          end
        end
        `TSC_ADDR_OSC_STATUS: s_d.bresp = `TSC_RESP_OKAY;
        `TSC_ADDR_INT_STATUS: begin
          if (s_q.wstrb[0]) begin
            int_clr = s_q.wdata[`TSC_INT_W-1:0];
          end
        end
        `TSC_ADDR_INT_MASK: begin
          if (s_q.wstrb[0]) begin
            s_d.int_mask = s_q.wdata[`TSC_INT_W-1:0];
          end
        end
        default: s_d.bresp = `TSC_RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // Read channel: one read in flight, data registered
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = '0;
      s_d.rresp = `TSC_RESP_OKAY;
      case (s_axi_araddr)
        `TSC_ADDR_OSC_CONTROL: begin
          s_d.rdata[`TSC_CTRL_SYSCLK_SELECT] = s_q.sysclk_select;
          s_d.rdata[`TSC_CTRL_INT_FREQ_SEL] = s_q.int_freq_sel;
          s_d.rdata[`TSC_CTRL_PLL_SOFT] = s_q.pll_soft_enable;
        end
        `TSC_ADDR_OSC_STATUS: begin
          s_d.rdata[`TSC_STAT_READY] = s_q.ext_osc_ready_flag;
          s_d.rdata[`TSC_STAT_PLL_LOCKED] = s_q.pll_locked;
          s_d.rdata[`TSC_STAT_TWO_SPEED] = s_q.two_speed;
          s_d.rdata[`TSC_STAT_ASLEEP] = (s_q.st == tsc_pkg::TSC_ST_SLEEP);
          s_d.rdata[`TSC_STAT_BUSY] = (s_q.st != tsc_pkg::TSC_ST_RUN) || mux_busy;
          s_d.rdata[`TSC_STAT_SRC] = mux_src;
        end
        `TSC_ADDR_INT_STATUS: s_d.rdata[`TSC_INT_W-1:0] = s_q.int_st;
        `TSC_ADDR_INT_MASK: s_d.rdata[`TSC_INT_W-1:0] = s_q.int_mask;
        default: s_d.rresp = `TSC_RESP_SLVERR;
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // A new event wins over a clear in the same cycle
    s_d.int_st = (s_q.int_st & ~int_clr) | int_set;
    s_d.irq = |(s_d.int_st & s_d.int_mask);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.int_freq_sel <= `TSC_INT_FREQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign sysclk_o = mux_clk;
  assign sysclk_src_o = mux_src;
  assign pll_active_o = s_q.pll_on;
  assign pll_locked_o = s_q.pll_locked;
  assign ext_osc_ready_flag = s_q.ext_osc_ready_flag;
  assign irq_o = s_q.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  ost_ready_a: assert property ($rose(s_q.ext_osc_ready_flag) |-> $past(ost_done))
    else $error("ready flag set without a finished start-up count");
  ready_switch_a: assert property ((s_q.st == tsc_pkg::TSC_ST_EDGES && !s_q.wait_sec && ost_done && !sleep_cmd)
    |=> (s_q.st == tsc_pkg::TSC_ST_RUN && s_q.want == s_q.tgt))
    else $error("no switch after start-up count finished");
  sleep_abort_a: assert property ((sleep_cmd && s_q.st == tsc_pkg::TSC_ST_EDGES)
    |=> (s_q.st == tsc_pkg::TSC_ST_SLEEP && !s_q.ext_osc_ready_flag))
    else $error("sleep did not abort the start-up count");
  two_speed_cfg_a: assert property (s_q.two_speed |-> (is_crystal(s_q.osc_mode_select) &&
    s_q.int_ext_switchover_en))
    else $error("two-speed start active without crystal mode and switchover");
  wake_start_a: assert property ((s_q.st == tsc_pkg::TSC_ST_SLEEP && wake_cmd)
    |=> (s_q.st == tsc_pkg::TSC_ST_START && s_q.boot))
    else $error("wake did not begin start-up");
  two_speed_run_a: assert property (s_q.two_speed |-> (mux_run && s_q.want != tsc_pkg::TSC_SRC_PRI))
    else $error("internal clock held during two-speed start");
  warmup_delay_a: assert property ((s_q.st == tsc_pkg::TSC_ST_START && s_q.boot && !sleep_cmd &&
    (tgt_now inside {tsc_pkg::TSC_SRC_LF, tsc_pkg::TSC_SRC_MF, tsc_pkg::TSC_SRC_HF}))
    |=> (s_q.st == tsc_pkg::TSC_ST_TIMED && s_q.cnt == 32'(WARMUP_CYC)))
    else $error("warm-up delay not applied");
  int_switch_a: assert property ((s_q.st == tsc_pkg::TSC_ST_START && !s_q.boot && !sleep_cmd &&
    (tgt_now inside {tsc_pkg::TSC_SRC_MF, tsc_pkg::TSC_SRC_HF}))
    |=> (s_q.st == tsc_pkg::TSC_ST_TIMED && s_q.cnt == 32'(INT_SWITCH_CYC)))
    else $error("internal switch delay not applied");
  sec_switch_a: assert property ($rose(s_q.want == tsc_pkg::TSC_SRC_SEC) |-> $past(sec_done))
    else $error("secondary oscillator chosen before its count");
  pll_lock_a: assert property ($rose(s_q.pll_locked) |-> ($past(s_q.pll_cnt) == '0 && $past(s_q.pll_on)))
    else $error("PLL reported locked before the lock delay");
  pll_config_a: assert property ((s_q.pll_config_enable && s_q.st != tsc_pkg::TSC_ST_CAPTURE) |=> s_q.pll_on)
    else $error("PLL off while configuration bit enables it");
endmodule
`default_nettype wire

// *** design/tsc_edge_cnt.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_edge_cnt (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic osc_lvl,
  input wire logic clear,
  input wire logic [10:0] target,
  output logic done
);
  tsc_pkg::tsc_edge_state_t s_q;
  tsc_pkg::tsc_edge_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = osc_lvl;
    if (clear) begin
      s_d.cnt = '0;
      s_d.done = 1'b0;
    end else if (!s_q.done && osc_lvl && !s_q.prev) begin
      s_d.cnt = s_q.cnt + 11'h001;
      s_d.done = (s_d.cnt == target);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule
`default_nettype wire

// *** design/tsc_params.svh ***
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

`define TSC_CLK_PERIOD_NS 100
`define TSC_AXI_AW 8

`define TSC_ADDR_OSC_CONTROL 8'h00
`define TSC_ADDR_OSC_STATUS 8'h04
`define TSC_ADDR_INT_STATUS 8'h08
`define TSC_ADDR_INT_MASK 8'h0c

`define TSC_CTRL_SYSCLK_SELECT 1:0
`define TSC_CTRL_INT_FREQ_SEL 3:2
`define TSC_CTRL_PLL_SOFT 4
`define TSC_INT_FREQ_RESET 2'h2

`define TSC_STAT_READY 0
`define TSC_STAT_PLL_LOCKED 1
`define TSC_STAT_TWO_SPEED 2
`define TSC_STAT_ASLEEP 3
`define TSC_STAT_BUSY 4
`define TSC_STAT_SRC 10:8

`define TSC_INT_W 3
`define TSC_INT_READY 0
`define TSC_INT_PLL_LOCK 1
`define TSC_INT_ABORT 2

`define TSC_MODE_LOW_POWER_XTAL 3'h0
`define TSC_MODE_XTAL 3'h1
`define TSC_MODE_HIGH_SPEED_XTAL 3'h2
`define TSC_MODE_EXT_RC 3'h3
`define TSC_MODE_INTERNAL 3'h4

`define TSC_SYSCLK_PRIMARY 2'h0
`define TSC_SYSCLK_SECONDARY 2'h1
`define TSC_SYSCLK_INTERNAL_BIT 1
`define TSC_FREQ_LOW 2'h0
`define TSC_FREQ_MID 2'h1

`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

`define TSC_OSC_STARTUP_COUNT 11'h400
`define TSC_EXT_DIRECT_COUNT 11'h002

`define TSC_INT_SWITCH_NS 2000
`define TSC_PLL_LOCK_NS 2000000
`define TSC_WARMUP_NS 2000
`define TSC_POWERUP_NS 64000
`define TSC_CYC(ns) (((ns) + `TSC_CLK_PERIOD_NS - 1) / `TSC_CLK_PERIOD_NS)

`endif

// *** design/tsc_pkg.sv ***
`default_nettype none
package tsc_pkg;
  typedef enum logic [2:0] {TSC_SRC_LF, TSC_SRC_MF, TSC_SRC_HF, TSC_SRC_PRI, TSC_SRC_SEC} tsc_src_t;
  typedef enum logic [1:0] {TSC_PH_IDLE, TSC_PH_OLD_LOW, TSC_PH_NEW_HIGH, TSC_PH_NEW_LOW} tsc_mux_ph_t;
  typedef enum logic [2:0] {
    TSC_ST_CAPTURE, TSC_ST_POWERUP, TSC_ST_START, TSC_ST_TIMED, TSC_ST_EDGES, TSC_ST_RUN, TSC_ST_SLEEP
  } tsc_state_t;
  typedef struct packed {logic prev; logic [10:0] cnt; logic done;} tsc_edge_state_t;
  typedef struct packed {tsc_src_t cur; tsc_mux_ph_t ph; logic clk;} tsc_mux_state_t;
  typedef struct packed {
    tsc_state_t st;
    logic [2:0] osc_mode_select;
    logic int_ext_switchover_en;
    logic pll_config_enable;
    logic powerup_timer_en;
    logic boot;
    logic two_speed;
    logic wait_sec;
    logic ext_osc_ready_flag;
    tsc_src_t tgt;
    tsc_src_t want;
    logic [31:0] cnt;
    logic [1:0] sysclk_select;
    logic [1:0] int_freq_sel;
    logic pll_soft_enable;
    logic [2:0] int_st;
    logic [2:0] int_mask;
    logic irq;
    logic pll_on;
    logic pll_locked;
    logic [31:0] pll_cnt;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsc_top_state_t;
endpackage
`default_nettype wire

// *** sim/two_speed_clock_startup_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_speed_clock_startup_test;
  localparam int LOCK = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] mode = 3'h1;
  logic swo = 1'b1, pllc = 1'b0, pwr = 1'b1, sleep_cmd = 1'b0, wake_cmd = 1'b0;
  logic lf = 1'b0, mf = 1'b0, hf = 1'b0, ext = 1'b0, sec = 1'b0;
  logic [7:0] cnt = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sysclk, pll_act, pll_lock, rdy, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [2:0] src;
  int ext_edges = 0, n_mismatch = 0, n_tests = 0, n, e0;
  int sys_edges = 0;
  logic sclk_prev = 1'b0;

  always #50 ref_clk = ~ref_clk;

  // Sources free-run; the crystal gives one rising edge every two cycles
  always @(posedge ref_clk) begin
    cnt <= cnt + 8'h01;
    lf <= cnt[3];
    mf <= cnt[1];
    hf <= ~hf;
    sec <= ~sec;
    ext <= ~ext;
    if (!ext) ext_edges <= ext_edges + 1;
    // System clock pulses, seen through the registered output
    sclk_prev <= sysclk;
    if (sysclk && !sclk_prev) sys_edges <= sys_edges + 1;
  end

  tsc_clock_startup #(.PLL_LOCK_CYC(LOCK), .POWERUP_CYC(5), .WARMUP_CYC(3)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .osc_mode_select(mode), .int_ext_switchover_en(swo),
    .pll_config_enable(pllc), .powerup_timer_en(pwr), .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd),
    .lf_osc_lvl(lf), .mf_osc_lvl(mf), .hf_osc_lvl(hf), .ext_osc_lvl(ext), .sec_osc_lvl(sec),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sysclk_o(sysclk), .sysclk_src_o(src), .pll_active_o(pll_act),
    .pll_locked_o(pll_lock), .ext_osc_ready_flag(rdy), .irq_o(irq));

  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("mismatch wait expected done seen timeout");
    test_done();
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Extra edge at the end keeps bready from being lowered and raised in one step
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (i == 40) timeout();
    @(posedge ref_clk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (i == 40) timeout();
    @(posedge ref_clk);
  endtask

  task automatic wait_for(input int w, input int lim, input logic [2:0] s);
    for (n = 0; n < lim; n++) begin
      if (w == 0 ? rdy === 1'b1 : w == 1 ? pll_lock === 1'b1 : src === s) break;
      @(posedge ref_clk);
    end
    if (n == lim) timeout();
  endtask

  task automatic pulse(input bit slp);
    if (slp) sleep_cmd <= 1'b1;
    else wake_cmd <= 1'b1;
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    wake_cmd <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    e0 = ext_edges;
    repeat (40) @(posedge ref_clk);
    check("src_wait", 32'h2, {29'h0, src});
    check("ready_wait", 32'h0, {31'h0, rdy});
    check("sysclk_runs", 32'h1, {31'h0, sys_edges > 0});
    wait_for(0, 3000, 3'h0);
    check("edges", 32'h1, {31'h0, (ext_edges - e0) inside {[1024:1032]}});
    wait_for(2, 40, 3'h3);
    axi_read(8'h04);
    check("status_src", 32'h301, {21'h0, rd[10:8], 7'h0, rd[0]});
    $display("test boot done");
    axi_write(8'h0c, 32'h1);
    @(posedge ref_clk);
    check("irq_on", 32'h1, {31'h0, irq});
    axi_read(8'h08);
    check("int_ready", 32'h1, rd);
    axi_write(8'h08, 32'h1);
    @(posedge ref_clk);
    check("irq_off", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    pulse(1'b1);
    pulse(1'b0);
    repeat (20) @(posedge ref_clk);
    pulse(1'b1);
    repeat (4) @(posedge ref_clk);
    check("ready_abort", 32'h0, {31'h0, rdy});
    axi_read(8'h08);
    check("int_abort", 32'h1, {31'h0, rd[2]});
    pulse(1'b0);
    e0 = ext_edges;
    wait_for(0, 3000, 3'h0);
    // Wake restarts the full count from zero
    check("edges_wake", 32'h1, {31'h0, (ext_edges - e0) inside {[1024:1032]}});
    $display("test sleep done");
    axi_write(8'h40, 32'h0);
    check("bresp_bad", 32'h2, {30'h0, rsp});
    axi_read(8'h40);
    check("rresp_bad", 32'h2, {30'h0, rsp});
    $display("test unmapped done");
    axi_write(8'h00, 32'h18);
    check("pll_on", 32'h1, {31'h0, pll_act});
    wait_for(1, 200, 3'h0);
    check("lock_time", 32'h1, {31'h0, n inside {[LOCK - 4:LOCK + 3]}});
    axi_write(8'h00, 32'h06);
    wait_for(2, 80, 3'h1);
    check("mf_time", 32'h1, {31'h0, n inside {[19:60]}});
    check("pll_off", 32'h0, {31'h0, pll_act});
    // Secondary source: 1024 edges at one per two cycles, then the handover
    axi_write(8'h00, 32'h1);
    wait_for(2, 2200, 3'h4);
    check("sec_time", 32'h1, {31'h0, n inside {[2040:2080]}});
    axi_write(8'h00, 32'h2);
    wait_for(2, 60, 3'h0);
    check("lf_src", 32'h0, {29'h0, src});
    $display("test switch done");
    reset <= 1'b1;
    mode <= 3'h5;
    pllc <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    wait_for(2, 40, 3'h3);
    check("pll_cfg", 32'h1, {31'h0, pll_act});
    axi_read(8'h04);
    check("two_speed_off", 32'h0, {31'h0, rd[2]});
    $display("test ext clock done");
    test_done();
  end
endmodule
`default_nettype wire
